// [include/spi_port_pkg.sv]
// shared constants for the serial port block
package spi_port_pkg;
   localparam int WORD_BITS  = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W      = 5;
   localparam int HALF_W     = 11;
   // base clock is the system clock divided by four
   localparam int BASE_DIV   = 4;
   // secondary prescaler divides by this minus its field
   localparam int SEC_BASE   = 8;
   localparam logic [6:0] PRIM_DIV_00 = 7'h40;
   localparam logic [6:0] PRIM_DIV_01 = 7'h10;
   localparam logic [6:0] PRIM_DIV_10 = 7'h04;
   localparam logic [6:0] PRIM_DIV_11 = 7'h01;
   localparam logic [CNT_W-1:0] LAST_BIT_8  = 5'h07;
   localparam logic [CNT_W-1:0] LAST_BIT_16 = 5'h0F;
   localparam logic [WORD_BITS-1:0] MASK_8  = 16'h00FF;
   localparam logic [WORD_BITS-1:0] MASK_16 = 16'hFFFF;
   localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
   localparam int MSB_8  = 7;
   localparam int MSB_16 = 15;
   typedef enum logic {ST_IDLE, ST_SHIFT} master_e;
endpackage

// [rtl/spi_port.sv]
// serial port with master/slave shift engine and transmit fifo
`timescale 1ns/100ps

// transmit fifo; DEPTH must be a power of two
module spi_port_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             clkEn,
   input  wire logic             flush,
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   output logic                  outValid,
   output logic [WIDTH-1:0]      outData,
   input  wire logic             outReady
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    rdPtr;
   logic [PW-1:0]    wrPtr;
   logic [CW-1:0]    count;
   logic [CW-1:0]    next_count;
   logic             push;
   logic             pop;

   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outValid = (count != '0);
   assign outData  = mem[rdPtr];

   always_comb begin
      next_count = count;
      if (push && !pop)
         next_count = count + 1'b1;
      else if (pop && !push)
         next_count = count - 1'b1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdPtr   <= '0;
         wrPtr   <= '0;
         count   <= '0;
         inReady <= 1'b0;
      end else if (clkEn) begin
         if (flush) begin
            rdPtr   <= '0;
            wrPtr   <= '0;
            count   <= '0;
            inReady <= 1'b1;
         end else begin
            if (push)
               wrPtr <= wrPtr + 1'b1;
            if (pop)
               rdPtr <= rdPtr + 1'b1;
            count   <= next_count;
            // registered ready keeps the write port glitch free
            inReady <= (next_count < CW'(DEPTH));
         end
      end
   end

   always_ff @(posedge clk) begin
      if (clkEn && push && !flush)
         mem[wrPtr] <= inData;
   end
endmodule // spi_port_fifo

// What this block does
// RULE1: one 16-bit shift register behind buffer
// RULE2: four lines: in, out, clock, select
// RULE3: master drives clock, slave receives it
// RULE4: eight or sixteen pulses shift both ways
// RULE5: completion sets flag, enable gates request
// RULE6: finished word moves into receive buffer
// RULE7: unread buffer: set overflow, drop word
// RULE8: overflow freezes port until buffer read
// RULE9: pending transmit word reloads shift register
// RULE10: write is transmit, read is receive
// RULE11: master prescales clock, starts on write
// RULE12: master interrupt at middle of last bit
// RULE13: slave interrupt after final bit latched
// RULE14: select low transfers, high releases output
// RULE15: quarter clock, then two prescalers
// RULE16: edge select picks output change edge
// RULE17: polarity bit sets clock idle level
// RULE18: msb bit 7 or 15; width change resets
// RULE19: select high resets all bit counters
// RULE20: output disable bit gives receive only
// RULE21: stop-in-idle halts during cpu idle
// RULE22: primary 64/16/4/1, secondary eight minus field
// RULE23: transmit and receive full flags
// RULE24: sample phase middle or end of bit
// RULE25: port enable gates all activity
module spi_port
   import spi_port_pkg::*;
#(
   parameter int FIFO_WORDS = spi_port_pkg::FIFO_DEPTH
) (
   input  wire logic                             clk,
   input  wire logic                             clkEn,
   input  wire logic                             resetn,
   input  wire logic                             portEnable,
   input  wire logic                             masterSelect,
   input  wire logic                             wordWidthSelect,
   input  wire logic                             clockIdleLevel,
   input  wire logic                             clockEdgeSelect,
   input  wire logic                             samplePhase,
   input  wire logic                             selectControlEnable,
   input  wire logic                             outPinDisable,
   input  wire logic                             stopInIdle,
   input  wire logic                             cpuIdle,
   input  wire logic [1:0]                       primaryDivider,
   input  wire logic [2:0]                       secondaryDivider,
   input  wire logic                             irqEnable,
   input  wire logic                             irqFlagClear,
   input  wire logic                             wrValid,
   input  wire logic [spi_port_pkg::WORD_BITS-1:0] wrData,
   output logic                                  wrReady,
   input  wire logic                             rdStrobe,
   output logic [spi_port_pkg::WORD_BITS-1:0]    rxWord,
   output logic                                  txFullFlag,
   output logic                                  rxFullFlag,
   output logic                                  rxOverflowFlag,
   output logic                                  irqFlag,
   output logic                                  irqRequest,
   output logic                                  busy,
   input  wire logic                             serialInPin,
   output logic                                  serialOutPin,
   output logic                                  serialOutOe,
   input  wire logic                             shiftClockIn,
   output logic                                  shiftClockOut,
   output logic                                  shiftClockOe,
   input  wire logic                             selectLowPin
);
   import spi_port_pkg::*;

   master_e                state;
   logic [WORD_BITS-1:0]   shiftReg;
   logic [WORD_BITS-1:0]   next_shiftReg;
   logic [WORD_BITS-1:0]   txHold;
   logic [WORD_BITS-1:0]   fifoData;
   logic [WORD_BITS-1:0]   rxCapture;
   logic [CNT_W-1:0]       bitCount;
   logic [CNT_W-1:0]       lastIdx;
   logic [HALF_W-1:0]      halfCnt;
   logic                   halfSel;
   logic                   sckPrev;
   logic                   lastWidth;
   logic                   fifoValid;
   logic                   fifoPop;
   logic                   hold;
   logic                   go;
   logic                   masterTick;
   logic                   midEvt;
   logic                   endEvt;
   logic                   lastBit;
   logic                   slaveOk;
   logic                   leadEdge;
   logic                   trailEdge;
   logic                   sampleEvt;
   logic                   shiftOutEvt;
   logic                   doneEvt;
   logic                   irqEvt;
   logic                   startEvt;
   logic                   loadTx;
   logic                   next_irqFlag;

   // half of one shift clock period in system clocks, less one
   function automatic logic [HALF_W-1:0] halfReload(
      input logic [1:0] prim,
      input logic [2:0] sec
   );
      logic [6:0]  p;
      logic [3:0]  s;
      logic [14:0] full;
      p = PRIM_DIV_11;
      case (prim)
         2'h0:    p = PRIM_DIV_00;
         2'h1:    p = PRIM_DIV_01;
         2'h2:    p = PRIM_DIV_10;
         default: p = PRIM_DIV_11;
      endcase
      s = 4'(SEC_BASE) - {1'b0, sec};
      full = 15'(BASE_DIV) * 15'(p) * 15'(s);
      return HALF_W'((full >> 1) - 15'h1); // RULE15 RULE22
   endfunction

   function automatic logic msbOf(
      input logic [WORD_BITS-1:0] w,
      input logic                 wide
   );
      return wide ? w[MSB_16] : w[MSB_8]; // RULE18
   endfunction

   // software writes queue here ahead of the transmit buffer
   spi_port_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (FIFO_WORDS)
   ) txFifo (
      .clk      (clk),
      .resetn   (resetn),
      .clkEn    (clkEn),
      .flush    (hold && !portEnable),
      .inValid  (wrValid),
      .inData   (wrData),
      .inReady  (wrReady),
      .outValid (fifoValid),
      .outData  (fifoData),
      .outReady (fifoPop)
   );
   assign fifoPop = !txFullFlag; // RULE10

   always_comb begin
      lastIdx = wordWidthSelect ? LAST_BIT_16 : LAST_BIT_8;
      lastBit = (bitCount == lastIdx);
      // width change or deselect restarts at the msb
      hold = !portEnable || (wordWidthSelect != lastWidth)
             || (!masterSelect && selectControlEnable
                 && selectLowPin); // RULE25 RULE18 RULE19 RULE14
      go = !hold && !(stopInIdle && cpuIdle); // RULE21
      masterTick = masterSelect && state == ST_SHIFT && go
                   && halfCnt == '0;
      midEvt = masterTick && !halfSel;
      endEvt = masterTick && halfSel;
      leadEdge  = (sckPrev == clockIdleLevel)
                  && (shiftClockIn != clockIdleLevel);
      trailEdge = (sckPrev != clockIdleLevel)
                  && (shiftClockIn == clockIdleLevel);
      // overflow blinds the slave to clock edges
      slaveOk = !masterSelect && go && !rxOverflowFlag; // RULE8 RULE3
      if (masterSelect) begin
         sampleEvt = (midEvt && !samplePhase)
                     || (endEvt && samplePhase); // RULE24
         shiftOutEvt = endEvt && !lastBit;
         doneEvt = endEvt && lastBit;
         irqEvt = midEvt && lastBit; // RULE12
      end else begin
         sampleEvt = slaveOk
                     && (clockEdgeSelect ? leadEdge : trailEdge);
         shiftOutEvt = slaveOk
                     && (clockEdgeSelect ? trailEdge : leadEdge); // RULE16
         doneEvt = sampleEvt && lastBit;
         irqEvt = doneEvt; // RULE13
      end
      startEvt = masterSelect && state == ST_IDLE && txFullFlag
                 && !rxOverflowFlag && go; // RULE11
      loadTx = txFullFlag && (startEvt || (!masterSelect && go
               && (doneEvt || (bitCount == '0 && !sampleEvt
                   && !shiftOutEvt)))); // RULE9
      rxCapture = sampleEvt ? {shiftReg[WORD_BITS-2:0], serialInPin}
                            : shiftReg; // RULE4
      rxCapture = rxCapture & (wordWidthSelect ? MASK_16 : MASK_8);
      next_shiftReg = shiftReg;
      if (loadTx)
         next_shiftReg = txHold;
      else if (sampleEvt)
         next_shiftReg = {shiftReg[WORD_BITS-2:0], serialInPin}; // RULE1
      next_irqFlag = irqEvt || (irqFlag && !irqFlagClear);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sckPrev   <= 1'b0;
         lastWidth <= 1'b0;
      end else if (clkEn) begin
         sckPrev   <= shiftClockIn;
         lastWidth <= wordWidthSelect;
      end
   end

   // master sequencing and shift clock generation
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state         <= ST_IDLE;
         halfCnt       <= '0;
         halfSel       <= 1'b0;
         shiftClockOut <= 1'b0;
      end else if (clkEn) begin
         if (hold || !masterSelect) begin
            state         <= ST_IDLE;
            halfSel       <= 1'b0;
            shiftClockOut <= clockIdleLevel; // RULE17
         end else if (startEvt) begin
            state   <= ST_SHIFT;
            halfCnt <= halfReload(primaryDivider, secondaryDivider);
            halfSel <= 1'b0;
            shiftClockOut <= clockIdleLevel ^ !clockEdgeSelect; // RULE16
         end else if (state == ST_SHIFT && go) begin
            if (masterTick) begin
               halfCnt <= halfReload(primaryDivider, secondaryDivider);
               halfSel <= !halfSel;
               if (doneEvt) begin
                  state         <= ST_IDLE;
                  shiftClockOut <= clockIdleLevel;
               end else if (!halfSel)
                  shiftClockOut <= clockIdleLevel ^ clockEdgeSelect;
               else
                  shiftClockOut <= clockIdleLevel ^ !clockEdgeSelect;
            end else
               halfCnt <= halfCnt - 1'b1;
         end else if (state == ST_IDLE)
            shiftClockOut <= clockIdleLevel; // RULE17
      end
   end

   // shift register, bit counter and serial output
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shiftReg     <= WORD_RESET;
         bitCount     <= '0;
         serialOutPin <= 1'b0;
         busy         <= 1'b0;
      end else if (clkEn) begin
         if (hold) begin
            bitCount <= '0; // RULE19 RULE18
            busy     <= 1'b0;
         end else begin
            shiftReg <= next_shiftReg;
            if (doneEvt || startEvt)
               bitCount <= '0;
            else if (masterSelect ? endEvt : sampleEvt)
               bitCount <= bitCount + 1'b1; // RULE4
            if (loadTx || shiftOutEvt)
               serialOutPin <= msbOf(next_shiftReg, wordWidthSelect);
            busy <= (state == ST_SHIFT && !doneEvt) || startEvt
                    || (!masterSelect && (bitCount != '0 || sampleEvt)
                        && !doneEvt);
         end
      end
   end

   // pin drivers; slave clock pin is never driven
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shiftClockOe <= 1'b0;
         serialOutOe  <= 1'b0;
      end else if (clkEn) begin
         shiftClockOe <= portEnable && masterSelect; // RULE3 RULE2
         serialOutOe  <= portEnable && !outPinDisable
                         && (masterSelect || !selectControlEnable
                             || !selectLowPin); // RULE14 RULE20
      end
   end

   // transmit holding buffer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txHold     <= WORD_RESET;
         txFullFlag <= 1'b0;
      end else if (clkEn) begin
         if (!portEnable)
            txFullFlag <= 1'b0;
         else if (fifoPop && fifoValid) begin
            txHold     <= fifoData;
            txFullFlag <= 1'b1; // RULE23
         end else if (loadTx)
            txFullFlag <= 1'b0; // RULE23
      end
   end

   // receive buffer; a completing word beats a same-cycle read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxWord         <= WORD_RESET;
         rxFullFlag     <= 1'b0;
         rxOverflowFlag <= 1'b0;
      end else if (clkEn) begin
         if (doneEvt && (!rxFullFlag || rdStrobe)) begin
            rxWord     <= rxCapture; // RULE6
            rxFullFlag <= 1'b1;
         end else if (rdStrobe)
            rxFullFlag <= 1'b0; // RULE10 RULE23
         if (doneEvt && rxFullFlag && !rdStrobe)
            rxOverflowFlag <= 1'b1; // RULE7
         else if (rdStrobe)
            rxOverflowFlag <= 1'b0; // RULE8
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqFlag    <= 1'b0;
         irqRequest <= 1'b0;
      end else if (clkEn) begin
         irqFlag    <= next_irqFlag; // RULE5
         irqRequest <= next_irqFlag && irqEnable; // RULE5
      end
   end

   a_rx_move: assert property (@(posedge clk) disable iff (!resetn) // RULE6
      clkEn && doneEvt && !rxFullFlag |=> rxFullFlag
      && rxWord == $past(rxCapture))
      else $error("finished word not moved to receive buffer");
   a_overflow_drop: assert property (@(posedge clk) // RULE7
      disable iff (!resetn)
      clkEn && doneEvt && rxFullFlag && !rdStrobe
      |=> rxOverflowFlag && $stable(rxWord))
      else $error("overflow not flagged or word not dropped");
   a_overflow_freeze: assert property (@(posedge clk) // RULE8
      disable iff (!resetn)
      rxOverflowFlag && !masterSelect |-> !sampleEvt && !doneEvt)
      else $error("slave shifted while overflowed");
   a_irq_gate: assert property (@(posedge clk) disable iff (!resetn) // RULE5
      clkEn && !irqEnable |=> !irqRequest)
      else $error("request raised while enable cleared");
   a_irq_mid: assert property (@(posedge clk) disable iff (!resetn) // RULE12
      clkEn && midEvt && lastBit |=> irqFlag ##0 state == ST_SHIFT)
      else $error("master interrupt not at middle of last bit");
   a_start_write: assert property (@(posedge clk) // RULE11
      disable iff (!resetn)
      clkEn && startEvt |=> state == ST_SHIFT && !txFullFlag
      && shiftClockOe)
      else $error("pending word did not start transfer");
   a_select_release: assert property (@(posedge clk) // RULE14
      disable iff (!resetn)
      clkEn && !masterSelect && selectControlEnable && selectLowPin
      |=> !serialOutOe && bitCount == '0)
      else $error("deselect did not release output");
   a_out_disable: assert property (@(posedge clk) // RULE20
      disable iff (!resetn)
      clkEn && outPinDisable |=> !serialOutOe)
      else $error("output driven while disabled");
   a_idle_level: assert property (@(posedge clk) // RULE17
      disable iff (!resetn)
      clkEn && masterSelect && portEnable && state == ST_IDLE
      && !startEvt |=> shiftClockOut == $past(clockIdleLevel))
      else $error("idle clock level wrong");
   c_master_done: cover property (@(posedge clk) disable iff (!resetn)
      masterSelect && doneEvt);
   c_slave_done: cover property (@(posedge clk) disable iff (!resetn)
      !masterSelect && doneEvt);
   c_overflow: cover property (@(posedge clk) disable iff (!resetn)
      $rose(rxOverflowFlag));
endmodule // spi_port

// [bench/spi_far_model.sv]
// far-side party: slave to the port's master mode, master to its slave mode
`timescale 1ns/100ps
module spi_far_model (
   input  wire logic clk,
   input  wire logic farSlave,
   input  wire logic wide,
   input  wire logic idleLevel,
   input  wire logic edgeSel,
   input  wire logic sckFromPort,
   input  wire logic dataFromPort,
   output logic      dataToPort,
   output logic      sckToPort,
   output logic      selectLow
);
   logic [15:0] txWord;
   logic [15:0] rxWord;
   logic [4:0]  cnt;
   logic [4:0]  idx;
   logic [4:0]  msb;
   logic        sckPrev;
   logic        sdiDrv;
   initial begin
      txWord    = 16'h0000;
      sdiDrv    = 1'b0;
      sckToPort = 1'b0;
      selectLow = 1'b1;
   end
   assign msb = wide ? 5'h0F : 5'h07;
   // bit index moves only on change edges, so data holds over the sample
   assign dataToPort = farSlave ? txWord[msb - idx] : sdiDrv;
   always @(posedge clk) begin
      sckPrev <= sckFromPort;
      if (!farSlave) begin
         cnt <= 5'h00;
         idx <= 5'h00;
      end else if (sckFromPort != sckPrev) begin
         if (sckFromPort == (idleLevel ^ edgeSel)) begin
            rxWord <= {rxWord[14:0], dataFromPort};
            cnt    <= (cnt == msb) ? 5'h00 : cnt + 5'h01;
         end else begin
            idx <= cnt;
         end
      end
   end
   // leading edge samples, trailing edge lets the port shift
   task automatic xfer(input logic [15:0] w, input int bits);
      selectLow <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < bits; i++) begin
         sdiDrv <= w[int'(msb) - i];
         repeat (4) @(posedge clk);
         rxWord    <= {rxWord[14:0], dataFromPort};
         sckToPort <= ~idleLevel;
         repeat (4) @(posedge clk);
         sckToPort <= idleLevel;
      end
      repeat (4) @(posedge clk);
      selectLow <= 1'b1;
      sdiDrv    <= ~sdiDrv;
      // deselect must be seen before a following frame pulls it low
      repeat (4) @(posedge clk);
   endtask
endmodule // spi_far_model

// [bench/spi_master_slave_port_bench.sv]
// self-checking bench for the serial port block
`timescale 1ns/100ps
module spi_master_slave_port_bench;
   import spi_port_pkg::*;
   logic clk, resetn, portEn, masterSel, wide, idle, cke, samp, selEn;
   logic outDis, stopIdle, cpuIdle, irqEn, irqClr, wrValid, rdStrobe;
   logic farSlave, wrReady, txFullFlag, rxFullFlag, rxOverflowFlag;
   logic irqFlag, irqRequest, busy, sdo, sdoOe, shiftClockOut, sckOe;
   logic farSdi, farSck, farSel, sckWire;
   logic [1:0]  prim;
   logic [2:0]  sec;
   logic [15:0] wrData, rxWord;
   int          nFail = 0;
   int          checkCount = 0;
   logic [1:0]  pcode [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
   logic [2:0]  scode [5] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h0};
   int          divs [5] = '{1, 4, 16, 64, 8};
   // shared clock pin: whoever has it enabled sets the level
   assign sckWire = sckOe ? shiftClockOut : farSck;

   spi_port dut_u (.clk(clk), .clkEn(1'b1), .resetn(resetn),
      .portEnable(portEn), .masterSelect(masterSel),
      .wordWidthSelect(wide), .clockIdleLevel(idle), .clockEdgeSelect(cke),
      .samplePhase(samp), .selectControlEnable(selEn),
      .outPinDisable(outDis), .stopInIdle(stopIdle), .cpuIdle(cpuIdle),
      .primaryDivider(prim), .secondaryDivider(sec), .irqEnable(irqEn),
      .irqFlagClear(irqClr), .wrValid(wrValid), .wrData(wrData),
      .wrReady(wrReady), .rdStrobe(rdStrobe), .rxWord(rxWord),
      .txFullFlag(txFullFlag), .rxFullFlag(rxFullFlag),
      .rxOverflowFlag(rxOverflowFlag), .irqFlag(irqFlag),
      .irqRequest(irqRequest), .busy(busy), .serialInPin(farSdi),
      .serialOutPin(sdo), .serialOutOe(sdoOe), .shiftClockIn(sckWire),
      .shiftClockOut(shiftClockOut), .shiftClockOe(sckOe),
      .selectLowPin(farSel));
   spi_far_model far_u (.clk(clk), .farSlave(farSlave), .wide(wide),
      .idleLevel(idle), .edgeSel(cke), .sckFromPort(sckWire),
      .dataFromPort(sdoOe ? sdo : ~sdo), .dataToPort(farSdi),
      .sckToPort(farSck), .selectLow(farSel));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] seen, exp);
      checkCount++;
      if (seen !== exp) begin
         nFail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic testDone();
      $display("checks %0d mismatches %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [15:0] d);
      wrValid <= 1'b1;
      wrData  <= d;
      do @(posedge clk); while (wrReady !== 1'b1);
      wrValid <= 1'b0;
   endtask

   task automatic rd();
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      @(posedge clk);
   endtask

   task automatic waitRx();
      for (int t = 0; rxFullFlag !== 1'b1 && t < 9000; t++) @(posedge clk);
   endtask

   // width change only while disabled, as software must
   task automatic cfg(input logic m, w, i);
      portEn   <= 1'b0;
      farSlave <= 1'b0;
      @(posedge clk);
      masterSel <= m;
      wide      <= w;
      idle      <= i;
      repeat (2) @(posedge clk);
      portEn   <= 1'b1;
      farSlave <= m;
      repeat (2) @(posedge clk);
      check("clock oe", 16'(sckOe), 16'(m));
   endtask

   // master word exchange, half period measured between clock toggles
   task automatic mx(input logic [15:0] d, f, input int h);
      int t;
      logic lvl;
      logic [15:0] m;
      m = wide ? 16'hFFFF : 16'h00FF;
      far_u.txWord <= f;
      irqClr <= 1'b1;
      wr(d);
      irqClr <= 1'b0;
      for (t = 0; shiftClockOut === idle && t < 9000; t++) @(posedge clk);
      lvl = shiftClockOut;
      for (t = 0; shiftClockOut === lvl && t < 300; t++) @(posedge clk);
      check("half period", 16'(t), 16'(h));
      for (t = 0; irqFlag !== 1'b1 && t < 9000; t++) @(posedge clk);
      check("rx full at irq", 16'(rxFullFlag), 16'h0000);
      check("busy at irq", 16'(busy), 16'h0001);
      waitRx();
      check("rx word", rxWord, f & m);
      check("far rx", far_u.rxWord & m, d & m);
      check("irq req", 16'(irqRequest), 16'(irqEn));
   endtask

   task automatic scenRates();
      cfg(1'b1, 1'b0, 1'b0);
      irqEn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         prim <= pcode[i];
         sec  <= scode[i];
         cke  <= ~i[0];
         samp <= i[1];
         mx(16'h00A5 ^ 16'(i), 16'h005A + 16'(i), 2 * divs[i]);
         rd();
      end
      cke <= 1'b1;
   endtask

   task automatic scenOverflow();
      sec <= 3'h7;
      mx(16'h0011, 16'h0022, 2);
      far_u.txWord <= 16'h0077;
      wr(16'h0033);
      for (int t = 0; rxOverflowFlag !== 1'b1 && t < 500; t++)
         @(posedge clk);
      check("kept word", rxWord, 16'h0022);
      wr(16'h0044);
      repeat (40) @(posedge clk);
      check("held", 16'({txFullFlag, shiftClockOut}), 16'h0002);
      rd();
      waitRx();
      check("resumed", 16'({rxOverflowFlag, rxWord}), 16'h0077);
      rd();
   endtask

   task automatic scenWide();
      cfg(1'b1, 1'b1, 1'b1);
      check("idle level", 16'(shiftClockOut), 16'h0001);
      irqEn <= 1'b0;
      mx(16'hBEEF, 16'h1234, 2);
      irqClr <= 1'b1;
      @(posedge clk);
      irqClr <= 1'b0;
      @(posedge clk);
      check("irq cleared", 16'(irqFlag), 16'h0000);
      rd();
      outDis <= 1'b1;
      wr(16'h0F0F);
      repeat (20) @(posedge clk);
      check("out disabled", 16'(sdoOe), 16'h0000);
      waitRx();
      rd();
      outDis <= 1'b0;
   endtask

   task automatic scenIdle();
      cfg(1'b1, 1'b0, 1'b0);
      stopIdle <= 1'b1;
      cpuIdle  <= 1'b1;
      wr(16'h0055);
      repeat (50) @(posedge clk);
      check("frozen", 16'({txFullFlag, shiftClockOut}), 16'h0002);
      cpuIdle <= 1'b0;
      waitRx();
      rd();
      stopIdle <= 1'b0;
   endtask

   task automatic scenSlave();
      cfg(1'b0, 1'b0, 1'b0);
      selEn <= 1'b1;
      wr(16'h00C3);
      repeat (4) @(posedge clk);
      check("deselected oe", 16'(sdoOe), 16'h0000);
      far_u.xfer(16'h0096, 8);
      waitRx();
      check("slave rx", rxWord, 16'h0096);
      check("slave tx", 16'(far_u.rxWord[7:0]), 16'h00C3);
      check("slave irq", 16'(irqFlag), 16'h0001);
      rd();
      far_u.xfer(16'h00FF, 3);
      far_u.xfer(16'h005A, 8);
      waitRx();
      check("restart rx", rxWord, 16'h005A);
      rd();
   endtask

   // select stays high; only the holding buffer takes one word
   task automatic scenFifo();
      int n;
      n = 0;
      wrValid <= 1'b1;
      repeat (20) begin
         wrData <= 16'(n);
         @(posedge clk);
         if (wrReady === 1'b1)
            n++;
      end
      wrValid <= 1'b0;
      check("fifo refuses", 16'(wrReady), 16'h0000);
      check("fifo depth", 16'(n), 16'(FIFO_DEPTH + 1));
      portEn <= 1'b0;
      repeat (3) @(posedge clk);
      check("off", 16'({txFullFlag, sdoOe, sckOe}), 16'h0000);
   endtask

   initial begin
      {resetn, portEn, masterSel, wide, idle, samp, selEn} = 7'h00;
      {outDis, stopIdle, cpuIdle, irqEn, irqClr, wrValid} = 6'h00;
      {rdStrobe, farSlave, prim, sec} = 7'h00;
      cke    = 1'b1;
      wrData = 16'h0000;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      check("reset flags", 16'({txFullFlag, rxFullFlag, rxOverflowFlag,
         irqFlag, busy}), 16'h0000);
      scenRates();
      scenOverflow();
      scenWide();
      scenIdle();
      scenSlave();
      scenFifo();
      testDone();
   end

   initial begin
      repeat (80000) @(posedge clk);
      nFail++;
      testDone();
   end
endmodule // spi_master_slave_port_bench
